// file: pkg/flash_seq_params.svh
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH
// timing
`define CLK_PERIOD_NS 100
`define ERASE_TIME_NS 2000000
`define PROG_TIME_NS 2000000
// geometry
`define PTR_W 22
`define BLOCK_WORDS 512
`define GROUP_WORDS 32
`define HOLD_COUNT 64
`define ERASED_WORD 16'hFFFF
// control register fields
`define CTL_FREE 4
`define CTL_ABORT 3
`define CTL_WP 2
`define CTL_START 1
// unlock keys
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'hAA
// apb map of the core agent
`define APB_PTR 8'h00
`define APB_DATA 8'h04
`define APB_CMD 8'h08
`define APB_STATUS 8'h0C
// command bits
`define CMD_READ 0
`define CMD_WRITE 1
`define CMD_ERASE 2
`define CMD_PROG 3
`define CMD_NOKEY 4
// status bits above the control byte
`define STAT_STALL 8
`define STAT_BUSY 9
`define STAT_IRQ 10
`endif

// file: pkg/flash_seq_pkg.sv
package flash_seq_pkg;
	typedef enum logic [1:0] {long_idle, long_erase, long_prog, long_bulk} long_state_type;
	typedef enum logic [1:0] {key_idle, key_half, key_armed} key_state_type;
	typedef enum logic [2:0] {
		seq_idle, seq_arm, seq_key1, seq_key2, seq_fire, seq_settle, seq_drain, seq_close
	} seq_state_type;
endpackage

// file: pkg/flash_core_if.sv
`timescale 1ns/100ps
interface flash_core_if;
	logic table_read_op;
	logic table_write_op;
	logic [21:0] program_pointer;
	logic [7:0] write_byte;
	logic ctrl_write;
	logic unlock_write;
	logic [7:0] reg_wdata;
	logic [7:0] transfer_latch;
	logic [7:0] ctrl_rdata;
	logic stall;
	modport device (
		input table_read_op, table_write_op, program_pointer, write_byte,
		input ctrl_write, unlock_write, reg_wdata,
		output transfer_latch, ctrl_rdata, stall
	);
	modport core (
		output table_read_op, table_write_op, program_pointer, write_byte,
		output ctrl_write, unlock_write, reg_wdata,
		input transfer_latch, ctrl_rdata, stall
	);
endinterface

// file: verilog/flash_self_program_ctrl.sv
// Functional notes
// - table read moves exactly one byte
// - table read loads pointed byte into latch
// - pointer bit zero picks high/low byte
// - self erase clears one whole 512-word block
// - bulk erase only from serial programming port
// - erase uses pointer 21:10, ignores 9:0
// - software sets write permit before long cycles
// - erase select plus start means block erase
// - start accepted only after 55h then 0AAh
// - software erase order with interrupts masked
// - start after unlock begins cycle, core stalls
// - stall whole long cycle, timer ends it
// - programming always covers 32-word group
// - sixty-four byte holding registers staged by writes
// - table write is short, no stall
// - software starts programming after loading holding registers
// - holding registers kept after programming
// - program each byte once between erases
// - start settable only, cleared at completion
// - erase select cleared when erase completes
// - abort flag on reset or improper start
// - pointer 5:0 picks holding register, 21:10 block
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "flash_seq_params.svh"
module flash_self_program_ctrl #(
	parameter int BLOCKS = 4,
	parameter int ERASE_CYCLES = (`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int PROG_CYCLES = (`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// processor core side
	flash_core_if.device core,
	// serial programming port and warm reset
	input wire logic serial_bulk_erase,
	input wire logic warm_reset
);
	localparam int WORDS = BLOCKS * `BLOCK_WORDS;
	localparam int WA = $clog2(WORDS);

	logic [15:0] mem [WORDS];
	logic [7:0] hold [`HOLD_COUNT];
	flash_seq_pkg::long_state_type state;
	flash_seq_pkg::key_state_type key;
	logic write_permit;
	logic erase_sel;
	logic start;
	logic abort_flag;
	logic [31:0] timer;
	logic [WA:0] idx;
	logic [WA-6:0] base;
	logic [7:0] latch;
	logic busy;
	logic go;
	logic accept;
	logic done;
	logic long_run;
	logic [WA-1:0] erase_addr;
	logic [WA-1:0] prog_addr;
	logic [WA-1:0] read_addr;
	logic [15:0] hold_word;
	logic [15:0] read_word;

	// core stalls for any long cycle and during bulk erase
	assign busy = state != flash_seq_pkg::long_idle;
	assign long_run = state == flash_seq_pkg::long_erase || state == flash_seq_pkg::long_prog;
	assign core.stall = busy;
	assign core.transfer_latch = latch;
	assign core.ctrl_rdata = {3'h0, erase_sel, abort_flag, write_permit, start, 1'b0};

	// start request and its qualification
	assign go = core.ctrl_write && core.reg_wdata[`CTL_START] && !start && !busy;
	assign accept = go && write_permit && key == flash_seq_pkg::key_armed;

	// erase and programming timers end their cycles; the last word index ends bulk erase
	assign done = (state == flash_seq_pkg::long_erase && timer == 32'(ERASE_CYCLES - 1))
		|| (state == flash_seq_pkg::long_prog && timer == 32'(PROG_CYCLES - 1))
		|| (state == flash_seq_pkg::long_bulk && idx == (WA + 1)'(WORDS - 1));

	// addresses: block from base upper bits, group from base, read by word
	assign erase_addr = {base[WA-6:4], idx[8:0]};
	assign prog_addr = {base, idx[4:0]};
	assign read_addr = core.program_pointer[WA:1];
	assign hold_word = {hold[{idx[4:0], 1'b1}], hold[{idx[4:0], 1'b0}]};
	assign read_word = mem[read_addr];

	// unlock key tracker; any other access breaks the sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key <= flash_seq_pkg::key_idle;
		end else if (core.unlock_write) begin
			if (core.reg_wdata == `KEY_FIRST) begin
				key <= flash_seq_pkg::key_half;
			end else if (core.reg_wdata == `KEY_SECOND && key == flash_seq_pkg::key_half) begin
				key <= flash_seq_pkg::key_armed;
			end else begin
				key <= flash_seq_pkg::key_idle;
			end
		end else if (core.ctrl_write || core.table_read_op || core.table_write_op) begin
			key <= flash_seq_pkg::key_idle;
		end
	end

	// control register bits; hardware set wins over software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			write_permit <= 1'b0;
			erase_sel <= 1'b0;
			start <= 1'b0;
			abort_flag <= 1'b0;
		end else begin
			if (core.ctrl_write) begin
				write_permit <= core.reg_wdata[`CTL_WP];
				abort_flag <= core.reg_wdata[`CTL_ABORT];
				if (!busy) begin
					erase_sel <= core.reg_wdata[`CTL_FREE];
				end
			end
			if (accept) begin
				start <= 1'b1;
			end
			if (done && long_run) begin
				start <= 1'b0;
				if (state == flash_seq_pkg::long_erase) begin
					erase_sel <= 1'b0;
				end
			end
			// improper start attempt
			if (go && !accept) begin
				abort_flag <= 1'b1;
			end
			// reset during self-timed cycle cuts it short
			if (warm_reset && long_run) begin
				abort_flag <= 1'b1;
				start <= 1'b0;
			end
		end
	end

	// long cycle sequencer with timer and word index
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= flash_seq_pkg::long_idle;
			timer <= 32'h0;
			idx <= '0;
			base <= '0;
		end else begin
			case (state)
				flash_seq_pkg::long_idle: begin
					timer <= 32'h0;
					idx <= '0;
					if (serial_bulk_erase) begin
						state <= flash_seq_pkg::long_bulk;
					end else if (accept) begin
						base <= core.program_pointer[WA:6];
						if (core.reg_wdata[`CTL_FREE]) begin
							state <= flash_seq_pkg::long_erase;
						end else begin
							state <= flash_seq_pkg::long_prog;
						end
					end
				end
				flash_seq_pkg::long_erase, flash_seq_pkg::long_prog: begin
					if (warm_reset || done) begin
						state <= flash_seq_pkg::long_idle;
					end else begin
						timer <= timer + 32'h1;
						if (state == flash_seq_pkg::long_erase
							? idx < (WA + 1)'(`BLOCK_WORDS)
							: idx < (WA + 1)'(`GROUP_WORDS)) begin
							idx <= idx + (WA + 1)'(1);
						end
					end
				end
				flash_seq_pkg::long_bulk: begin
					if (done) begin
						state <= flash_seq_pkg::long_idle;
					end else begin
						idx <= idx + (WA + 1)'(1);
					end
				end
				default: begin
					state <= flash_seq_pkg::long_idle;
				end
			endcase
		end
	end

	// array cells: erase sets ones, programming can only clear bits
	always_ff @(posedge pclk) begin
		if (state == flash_seq_pkg::long_erase && idx < (WA + 1)'(`BLOCK_WORDS)) begin
			mem[erase_addr] <= `ERASED_WORD;
		end else if (state == flash_seq_pkg::long_prog && idx < (WA + 1)'(`GROUP_WORDS)) begin
			mem[prog_addr] <= mem[prog_addr] & hold_word;
		end else if (state == flash_seq_pkg::long_bulk) begin
			mem[idx[WA-1:0]] <= `ERASED_WORD;
		end
	end

	// table read: one byte, bit zero picks the half
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch <= 8'h00;
		end else if (core.table_read_op && !busy) begin
			latch <= core.program_pointer[0] ? read_word[15:8] : read_word[7:0];
		end
	end

	// holding registers: short write only, never cleared by programming
	always_ff @(posedge pclk) begin
		if (core.table_write_op && !busy) begin
			hold[core.program_pointer[5:0]] <= core.write_byte;
		end
	end
endmodule

// file: verilog/flash_core_agent.sv
`timescale 1ns/100ps
`include "flash_seq_params.svh"
module flash_core_agent (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// flash controller side
	flash_core_if.core core,
	// interrupt gate of the core
	output logic global_irq_allow
);
	flash_seq_pkg::seq_state_type seq;
	logic [21:0] ptr;
	logic [7:0] data_byte;
	logic mode_erase;
	logic no_key;
	logic rd_pulse;
	logic wr_pulse;
	logic ctrl_pulse;
	logic key_pulse;
	logic [7:0] wdata;
	logic wr_acc;
	logic mapped;
	logic cmd_ok;
	logic [31:0] rd_mux;

	assign core.table_read_op = rd_pulse;
	assign core.table_write_op = wr_pulse;
	assign core.ctrl_write = ctrl_pulse;
	assign core.unlock_write = key_pulse;
	assign core.reg_wdata = wdata;
	assign core.program_pointer = ptr;
	assign core.write_byte = data_byte;

	// apb decode; no wait states, unmapped answers with an error
	assign mapped = paddr == `APB_PTR || paddr == `APB_DATA || paddr == `APB_CMD
		|| paddr == `APB_STATUS;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_acc = psel && penable && pwrite && mapped;
	// commands are dropped while a sequence runs or the core is stalled
	assign cmd_ok = wr_acc && paddr == `APB_CMD && seq == flash_seq_pkg::seq_idle && !core.stall;

	// read mux
	always_comb begin
		rd_mux = 32'h0;
		if (paddr == `APB_PTR) begin
			rd_mux = {10'h000, ptr};
		end else if (paddr == `APB_DATA) begin
			rd_mux = {24'h000000, core.transfer_latch};
		end else if (paddr == `APB_STATUS) begin
			// busy covers the closing control write so permit is seen dropped
			rd_mux = {21'h000000, global_irq_allow, seq != flash_seq_pkg::seq_idle || ctrl_pulse,
				core.stall, core.ctrl_rdata};
		end
	end

	// read data captured in the setup cycle so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// pointer and data byte registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr <= 22'h000000;
			data_byte <= 8'h00;
		end else if (wr_acc && paddr == `APB_PTR) begin
			ptr <= pwdata[21:0];
		end else if (wr_acc && paddr == `APB_DATA) begin
			data_byte <= pwdata[7:0];
		end
	end

	// core sequencer: table ops are single pulses, long ops follow the unlock order unless no_key skips the two keys
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq <= flash_seq_pkg::seq_idle;
			mode_erase <= 1'b0;
			no_key <= 1'b0;
			rd_pulse <= 1'b0;
			wr_pulse <= 1'b0;
			ctrl_pulse <= 1'b0;
			key_pulse <= 1'b0;
			wdata <= 8'h00;
			global_irq_allow <= 1'b1;
		end else begin
			rd_pulse <= 1'b0;
			wr_pulse <= 1'b0;
			ctrl_pulse <= 1'b0;
			key_pulse <= 1'b0;
			case (seq)
				flash_seq_pkg::seq_idle: begin
					if (cmd_ok) begin
						if (pwdata[`CMD_READ]) begin
							rd_pulse <= 1'b1;
						end else if (pwdata[`CMD_WRITE]) begin
							wr_pulse <= 1'b1;
						end else if (pwdata[`CMD_ERASE] || pwdata[`CMD_PROG]) begin
							mode_erase <= pwdata[`CMD_ERASE];
							no_key <= pwdata[`CMD_NOKEY];
							seq <= flash_seq_pkg::seq_arm;
						end
					end
				end
				flash_seq_pkg::seq_arm: begin
					// permit and erase select first, interrupts off
					ctrl_pulse <= 1'b1;
					wdata <= {3'h0, mode_erase, core.ctrl_rdata[`CTL_ABORT], 3'b100};
					global_irq_allow <= 1'b0;
					seq <= no_key ? flash_seq_pkg::seq_fire : flash_seq_pkg::seq_key1;
				end
				flash_seq_pkg::seq_key1: begin
					key_pulse <= 1'b1;
					wdata <= `KEY_FIRST;
					seq <= flash_seq_pkg::seq_key2;
				end
				flash_seq_pkg::seq_key2: begin
					key_pulse <= 1'b1;
					wdata <= `KEY_SECOND;
					seq <= flash_seq_pkg::seq_fire;
				end
				flash_seq_pkg::seq_fire: begin
					ctrl_pulse <= 1'b1;
					wdata <= {3'h0, mode_erase, core.ctrl_rdata[`CTL_ABORT], 3'b110};
					seq <= flash_seq_pkg::seq_settle;
				end
				flash_seq_pkg::seq_settle: begin
					seq <= flash_seq_pkg::seq_drain;
				end
				flash_seq_pkg::seq_drain: begin
					if (!core.stall) begin
						seq <= flash_seq_pkg::seq_close;
					end
				end
				flash_seq_pkg::seq_close: begin
					// interrupts back on, permit dropped
					ctrl_pulse <= 1'b1;
					wdata <= {4'h0, core.ctrl_rdata[`CTL_ABORT], 3'b000};
					global_irq_allow <= 1'b1;
					seq <= flash_seq_pkg::seq_idle;
				end
				default: begin
					seq <= flash_seq_pkg::seq_idle;
				end
			endcase
		end
	end
endmodule

// file: tb/flash_self_program_ctrl_asserts.sv
`timescale 1ns/100ps
`include "flash_seq_params.svh"
module flash_self_program_ctrl_asserts #(
	parameter int ERASE_CYCLES = 600,
	parameter int PROG_CYCLES = 40,
	parameter int BULK_CYCLES = 2048
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// core to device
	input wire logic table_read_op,
	input wire logic table_write_op,
	input wire logic ctrl_write,
	input wire logic unlock_write,
	input wire logic [7:0] reg_wdata,
	// far-side events
	input wire logic serial_bulk_erase,
	input wire logic warm_reset,
	// device to core
	input wire logic [7:0] transfer_latch,
	input wire logic [7:0] ctrl_rdata,
	input wire logic stall
);
	int stall_len;
	logic bulk_run;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// own count of stall cycles, independent of the device timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_len <= 0;
		end else begin
			stall_len <= stall ? stall_len + 1 : 0;
		end
	end
	// remembers that the current stall came from the serial port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bulk_run <= 1'b0;
		end else if (!stall) begin
			bulk_run <= serial_bulk_erase;
		end
	end
	// the two unlock keys back to back
	sequence key_pair;
		unlock_write && reg_wdata == `KEY_FIRST ##1 unlock_write && reg_wdata == `KEY_SECOND;
	endsequence
	sequence permitted_start;
		ctrl_write && reg_wdata[`CTL_START] && ctrl_rdata[`CTL_WP] && !stall;
	endsequence
	chk_key_starts: assert property (key_pair ##1 permitted_start |=> stall)
		else $error("unlocked start gave no stall");
	chk_lone_start: assert property (ctrl_write && reg_wdata[`CTL_START] && !stall
		&& !$past(unlock_write) |=> !stall && ctrl_rdata[`CTL_ABORT])
		else $error("start without keys was not refused");
	chk_stall_length: assert property ($fell(stall) && !$past(warm_reset) |->
		(bulk_run ? stall_len == BULK_CYCLES
		: (stall_len == PROG_CYCLES || stall_len == ERASE_CYCLES)))
		else $error("stall length differs from timer");
	chk_done_clears: assert property ($fell(stall) && !$past(warm_reset) |->
		!ctrl_rdata[`CTL_START] && !ctrl_rdata[`CTL_FREE])
		else $error("start or erase select left set");
	chk_start_held: assert property (stall && !bulk_run |-> ctrl_rdata[`CTL_START])
		else $error("start cleared during cycle");
	chk_cut_abort: assert property (warm_reset && stall && !bulk_run |=>
		!stall && ctrl_rdata[`CTL_ABORT])
		else $error("cut cycle not flagged");
	chk_quiet_stall: assert property (stall |-> !table_read_op && !table_write_op)
		else $error("table access during stall");
	chk_short_write: assert property (table_write_op |=> !stall [*2])
		else $error("table write stalled");
	chk_latch_source: assert property ($changed(transfer_latch) |-> $past(table_read_op))
		else $error("latch changed without table read");
endmodule

// file: tb/tb_flash_self_program_ctrl.sv
`timescale 1ns/100ps
`include "flash_seq_params.svh"
module tb_flash_self_program_ctrl;
	typedef struct {logic [21:0] ptr; logic [7:0] exp;} row_type;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] seen;
	logic err;
	logic serial_bulk_erase = 1'b0;
	logic warm_reset = 1'b0;
	int failures = 0;
	int n_compared = 0;
	// programmed groups hold A5 xor index, the rest stays erased
	row_type rows [8] = '{'{22'h000040, 8'hA5}, '{22'h000041, 8'hA4}, '{22'h00007F, 8'h9A},
		'{22'h000080, 8'hA5}, '{22'h00003F, 8'hFF}, '{22'h0000C0, 8'hFF},
		'{22'h000400, 8'hFF}, '{22'h0007FF, 8'hFF}};
	flash_core_if link ();
	flash_self_program_ctrl #(.ERASE_CYCLES(600), .PROG_CYCLES(40)) flash_self_program_ctrl_i (
		.pclk(pclk), .presetn(presetn), .core(link), .serial_bulk_erase(serial_bulk_erase),
		.warm_reset(warm_reset));
	flash_core_agent flash_core_agent_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .core(link), .global_irq_allow());
	flash_self_program_ctrl_asserts #(.ERASE_CYCLES(600), .PROG_CYCLES(40))
		flash_self_program_ctrl_asserts_i (.pclk(pclk), .presetn(presetn),
		.table_read_op(link.table_read_op), .table_write_op(link.table_write_op),
		.ctrl_write(link.ctrl_write), .unlock_write(link.unlock_write),
		.reg_wdata(link.reg_wdata), .serial_bulk_erase(serial_bulk_erase),
		.warm_reset(warm_reset), .transfer_latch(link.transfer_latch),
		.ctrl_rdata(link.ctrl_rdata), .stall(link.stall));
	always #50 pclk = ~pclk;
	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic complete_run();
		if (failures == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// one apb transfer, idle edge first so psel never changes twice in a step
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		seen = prdata;
		err = pslverr;
		if (n >= 100) begin
			failures++;
			complete_run();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// latch is loaded one cycle after the command; the task waits two cycles before reading it
	task automatic read_byte(input logic [21:0] ptr);
		apb(1'b1, `APB_PTR, {10'h000, ptr});
		apb(1'b1, `APB_CMD, 32'h1);
		repeat (2) @(posedge pclk);
		apb(1'b0, `APB_DATA, 32'h0);
	endtask
	// poll status until the given bit drops; a hang ends the run
	task automatic poll(input int bitpos);
		int n;
		n = 0;
		do begin
			apb(1'b0, `APB_STATUS, 32'h0);
			n++;
		end while (seen[bitpos] !== 1'b0 && n < 1000);
		if (seen[bitpos] !== 1'b0) begin
			failures++;
			complete_run();
		end
	endtask
	// start a long cycle, look at it mid-way, then poll until idle
	task automatic long_cycle(input logic [21:0] ptr, input logic [31:0] cmd,
		input logic [31:0] done);
		apb(1'b1, `APB_PTR, {10'h000, ptr});
		apb(1'b1, `APB_CMD, cmd);
		repeat (8) @(posedge pclk);
		apb(1'b0, `APB_STATUS, 32'h0);
		if (!done[`CTL_ABORT]) begin
			check("stall status", seen & 32'h700, 32'h300);
		end
		poll(`STAT_BUSY);
		check("idle status", seen, done);
	endtask
	initial begin
		int i;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `APB_STATUS, 32'h0);
		check("reset status", seen, 32'h400);
		apb(1'b0, 8'h10, 32'h0);
		check("unmapped error", {31'h0, err}, 32'h1);
		check("unmapped data", seen, 32'h0);
		// low pointer bits set to show they are ignored
		long_cycle(22'h0003FF, 32'h4, 32'h400);
		long_cycle(22'h0007FF, 32'h4, 32'h400);
		for (i = 0; i < 64; i++) begin
			apb(1'b1, `APB_PTR, 32'(i));
			apb(1'b1, `APB_DATA, 32'(8'hA5 ^ i[7:0]));
			apb(1'b1, `APB_CMD, 32'h2);
		end
		long_cycle(22'h000040, 32'h8, 32'h400);
		// second group reuses the kept holding bytes
		long_cycle(22'h000080, 32'h8, 32'h400);
		long_cycle(22'h0000C0, 32'h18, 32'h408);
		foreach (rows[r]) begin
			read_byte(rows[r].ptr);
			check("flash byte", seen, {24'h0, rows[r].exp});
		end
		// serial bulk erase wipes the whole array, abort flag left alone
		serial_bulk_erase <= 1'b1;
		@(posedge pclk);
		serial_bulk_erase <= 1'b0;
		poll(`STAT_STALL);
		check("bulk status", seen, 32'h408);
		read_byte(22'h000040);
		check("bulk erased", seen, 32'hFF);
		// reset in mid-run clears the abort flag again
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `APB_STATUS, 32'h0);
		check("second reset", seen, 32'h400);
		// warm reset in mid-erase cuts the cycle short and flags it
		apb(1'b1, `APB_PTR, 32'h0);
		apb(1'b1, `APB_CMD, 32'h4);
		repeat (20) @(posedge pclk);
		warm_reset <= 1'b1;
		@(posedge pclk);
		warm_reset <= 1'b0;
		poll(`STAT_BUSY);
		check("cut status", seen, 32'h408);
		complete_run();
	end
endmodule
